/* src/dpi_top.sv */
/*
  Device side of the DRAM pin interface: command decode, mode bits,
  termination control, masked writes into a FIFO and strobed reads.
  Assumes the pins are synchronous to CORE_CLK_IN and an APB master.
*/
// Register access over APB and the register addresses were decided locally.

// ----------------------------------------
// Storage FIFO
// ----------------------------------------
module dpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Pointer arithmetic wraps only for a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dpi_fifo DEPTH must be a power of two, at least 2");
  end

  // Extra pointer bit tells full from empty
  assign count_out = wr_ptr - rd_ptr;
  assign in_ready_out = count_out != (AW + 1)'(DEPTH);
  assign out_valid_out = count_out != '0;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage carries no reset, only pointers do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW + 1)'(push);
      rd_ptr <= rd_ptr + (AW + 1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Top of the pin interface
// ----------------------------------------
module dpi_top import dpi_pkg::*; #(
  parameter bit DEFAULT_X8 = 1'b1,
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic ROW_CMD_STROBE_N_IN,
  input wire logic COL_CMD_STROBE_N_IN,
  input wire logic WRITE_CMD_STROBE_N_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [2:0] BANK_IN,
  input wire logic TERMINATION_ENABLE_IN,
  input wire logic WRITE_BYTE_MASK_IN,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic [7:0] DQ_OE_OUT,
  input wire logic DATA_STROBE_IN,
  output logic DATA_STROBE_OUT,
  output logic DATA_STROBE_COMP_OUT,
  output logic DATA_STROBE_OE_OUT,
  output logic WRITE_READY_OUT,
  output logic [7:0] TERM_DQ_OUT,
  output logic TERM_DQS_OUT,
  output logic TERM_MASK_OUT,
  output logic TERM_STROBE_OUT
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  logic cfg_x8;
  logic [1:0] burst_mode;
  logic rtt_en;
  logic tstrobe_en;
  dpi_state_type state;
  logic [3:0] beats_left;
  logic [3:0] next_beats;
  logic term_on;
  logic dqs_prev;
  logic [7:0] dq_out;
  logic dqs_out;
  logic rd_oe;
  logic [15:0] stored_cnt;
  logic [15:0] masked_cnt;
  logic [31:0] prdata;
  logic [31:0] rd_mux;
  logic [31:0] status;
  dpi_cmd_type cmd;
  logic [7:0] dq_mask;
  logic mask_active;
  logic write_beat;
  logic push;
  logic pop;
  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [CW-1:0] fifo_count;
  logic apb_wr;
  logic mapped;

  // Command truth table; deselect wins over any strobe pattern
  function automatic dpi_cmd_type cmd_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    if (cs_n) begin
      return CMD_NOP;
    end
    case ({ras_n, cas_n, we_n})
      3'b000: return CMD_LOAD;
      3'b101: return CMD_READ;
      3'b100: return CMD_WRITE;
      3'b111: return CMD_NOP;
      default: return CMD_OTHER;
    endcase
  endfunction

  // Beat count of a burst from the mode field and the chop pin
  function automatic logic [3:0] burst_beats(input logic [1:0] mode, input logic full_len);
    case (mode)
      BURST_OTF: return full_len ? BEATS_BL8 : BEATS_BC4;
      BURST_CHOP4: return BEATS_BC4;
      default: return BEATS_BL8;
    endcase
  endfunction

  // ----------------------------------------
  // Decode and width steering
  // ----------------------------------------
  // Pins are taken on the rising edge only
  assign cmd = cmd_decode(CHIP_SELECT_N_IN, ROW_CMD_STROBE_N_IN,
                          COL_CMD_STROBE_N_IN, WRITE_CMD_STROBE_N_IN);
  assign next_beats = burst_beats(burst_mode, ADDR_IN[CHOP_ADDR_BIT]);
  assign dq_mask = cfg_x8 ? DQ_MASK_X8 : DQ_MASK_X4;
  assign mask_active = !(cfg_x8 && tstrobe_en);
  // The controller centres one strobe toggle per beat, so a toggle marks a beat
  assign write_beat = (state == ST_WRITE) && (DATA_STROBE_IN != dqs_prev);
  assign push = write_beat && !(mask_active && WRITE_BYTE_MASK_IN);
  assign pop = (state == ST_READ) && fifo_valid;

  dpi_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .in_valid_in(push),
    .in_data_in(DQ_IN & dq_mask),
    .in_ready_out(fifo_ready),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(state == ST_READ),
    .count_out(fifo_count)
  );

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  // Device reset acts without the clock; only idle accepts commands
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= ST_IDLE;
      beats_left <= 4'h0;
    end else if (RST_IN) begin
      state <= ST_IDLE;
      beats_left <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd == CMD_WRITE) begin
            state <= ST_WRITE;
            beats_left <= next_beats;
          end else if (cmd == CMD_READ) begin
            state <= ST_READ;
            beats_left <= next_beats;
          end
        end
        ST_WRITE: begin
          if (write_beat) begin
            beats_left <= beats_left - 4'h1;
            if (beats_left == 4'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          // An empty FIFO stalls the burst instead of inventing data
          if (pop) begin
            beats_left <= beats_left - 4'h1;
            if (beats_left == 4'h1) begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Mode bits come only from a load command while idle
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      burst_mode <= BURST_RESET;
      rtt_en <= RTT_RESET;
      tstrobe_en <= TSTROBE_RESET;
    end else if (RST_IN) begin
      burst_mode <= BURST_RESET;
      rtt_en <= RTT_RESET;
      tstrobe_en <= TSTROBE_RESET;
    end else if (state == ST_IDLE && cmd == CMD_LOAD) begin
      if (BANK_IN == MR_SEL_BURST) begin
        burst_mode <= ADDR_IN[1:0];
      end else if (BANK_IN == MR_SEL_TERM) begin
        rtt_en <= ADDR_IN[TERM_EN_BIT];
        tstrobe_en <= ADDR_IN[TSTROBE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Termination
  // ----------------------------------------
  // Registered pin, gated by the mode bit so a disabled setting ignores it
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      term_on <= 1'b0;
    end else if (RST_IN) begin
      term_on <= 1'b0;
    end else begin
      term_on <= rtt_en && TERMINATION_ENABLE_IN;
    end
  end

  // Only the active lines, the strobe, the strobe pair and the mask ball terminate
  assign TERM_DQ_OUT = {8{term_on}} & dq_mask;
  assign TERM_DQS_OUT = term_on;
  assign TERM_MASK_OUT = term_on && mask_active;
  assign TERM_STROBE_OUT = term_on && cfg_x8 && tstrobe_en;
  assign WRITE_READY_OUT = fifo_ready;

  // ----------------------------------------
  // Read drive
  // ----------------------------------------
  // Data and strobe flip on the same edge, so their edges line up
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dq_out <= 8'h00;
      dqs_out <= 1'b0;
      rd_oe <= 1'b0;
    end else if (RST_IN) begin
      dq_out <= 8'h00;
      dqs_out <= 1'b0;
      rd_oe <= 1'b0;
    end else begin
      if (pop) begin
        dq_out <= fifo_data & dq_mask;
        dqs_out <= !dqs_out;
      end
      rd_oe <= pop || (rd_oe && state == ST_READ);
    end
  end

  assign DQ_OUT = dq_out;
  assign DQ_OE_OUT = {8{rd_oe}} & dq_mask;
  assign DATA_STROBE_OUT = dqs_out;
  assign DATA_STROBE_COMP_OUT = !dqs_out;
  assign DATA_STROBE_OE_OUT = rd_oe;

  // Write strobe history and beat counters
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dqs_prev <= 1'b0;
      stored_cnt <= 16'h0000;
      masked_cnt <= 16'h0000;
    end else if (RST_IN) begin
      dqs_prev <= 1'b0;
      stored_cnt <= 16'h0000;
      masked_cnt <= 16'h0000;
    end else begin
      dqs_prev <= DATA_STROBE_IN;
      stored_cnt <= stored_cnt + 16'(push && fifo_ready);
      masked_cnt <= masked_cnt + 16'(write_beat && !push);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign mapped = PADDR_IN == ADDR_CONFIG || PADDR_IN == ADDR_STATUS || PADDR_IN == ADDR_COUNT;

  // Width change mid-burst is not guarded; software sets it while idle
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      cfg_x8 <= DEFAULT_X8;
    end else if (apb_wr && PADDR_IN == ADDR_CONFIG) begin
      cfg_x8 <= PWDATA_IN[CONFIG_X8_BIT];
    end
  end

  always_comb begin
    status = (32'(fifo_count) << STAT_FILL_LSB) | (32'(state) << STAT_STATE_LSB)
           | (32'(burst_mode) << STAT_BURST_LSB) | (32'(tstrobe_en) << STAT_TSTROBE_BIT)
           | (32'(rtt_en) << STAT_RTT_BIT) | (32'(term_on) << STAT_TERM_BIT);
    case (PADDR_IN)
      ADDR_CONFIG: rd_mux = 32'(cfg_x8) << CONFIG_X8_BIT;
      ADDR_STATUS: rd_mux = status;
      ADDR_COUNT: rd_mux = (32'(masked_cnt) << COUNT_MASKED_LSB) | 32'(stored_cnt);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is caught in the setup cycle so it leaves a flip-flop
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      prdata <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN) begin
      prdata <= rd_mux;
    end
  end

  assign PRDATA_OUT = prdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN || !RESET_N_IN);

  sequence s_masked_beat;
    write_beat && mask_active && WRITE_BYTE_MASK_IN;
  endsequence
  sequence s_chop_write;
    state == ST_IDLE && cmd == CMD_WRITE && burst_mode == BURST_OTF && !ADDR_IN[CHOP_ADDR_BIT];
  endsequence
  sequence s_read_cmd;
    state == ST_IDLE && cmd == CMD_READ;
  endsequence

  AST_MASK_DROP: assert property (s_masked_beat |=> masked_cnt == $past(masked_cnt) + 16'h1
                                  && stored_cnt == $past(stored_cnt))
    else $error("masked write beat was stored");
  AST_TERM_FOLLOW: assert property (rtt_en && TERMINATION_ENABLE_IN |=> TERM_DQS_OUT)
    else $error("termination not on after enable");
  AST_TERM_SCOPE: assert property (TERM_DQ_OUT == ({8{TERM_DQS_OUT}} & dq_mask))
    else $error("termination on an inactive data line");
  AST_TERM_IGNORED: assert property (!rtt_en |=> !TERM_DQS_OUT && !TERM_STROBE_OUT)
    else $error("termination pin not ignored while disabled");
  AST_READ_START: assert property (s_read_cmd |=> state == ST_READ ##0 beats_left != 4'h0)
    else $error("read command not decoded");
  AST_STROBE_ALIGN: assert property ($changed(DQ_OUT) && rd_oe |-> $changed(DATA_STROBE_OUT))
    else $error("read data edge without strobe edge");
  AST_TSTROBE_MASK: assert property (cfg_x8 && tstrobe_en && WRITE_BYTE_MASK_IN && write_beat
                                     |-> push)
    else $error("mask active with term_strobe enabled");
  AST_X4_UPPER: assert property (!cfg_x8 |-> DQ_OE_OUT[7:4] == 4'h0 && !TERM_STROBE_OUT)
    else $error("no-function balls active in x4");
  AST_DESELECT: assert property (CHIP_SELECT_N_IN && state == ST_IDLE |=> state == ST_IDLE
                                 && $stable(burst_mode))
    else $error("command taken while deselected");
  AST_CHOP: assert property (s_chop_write |=> beats_left == BEATS_BC4 ##1 state == ST_WRITE)
    else $error("chop did not give four beats");
endmodule

/* src/dpi_pkg.sv */
/*
  Constants and types shared by the DRAM pin, command and data interface.
  Assumes a single core clock that is also the sampling clock of the pins.
*/
package dpi_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam int CONFIG_X8_BIT = 0;
  localparam int STAT_TERM_BIT = 0;
  localparam int STAT_RTT_BIT = 1;
  localparam int STAT_TSTROBE_BIT = 2;
  localparam int STAT_BURST_LSB = 3;
  localparam int STAT_STATE_LSB = 5;
  localparam int STAT_FILL_LSB = 8;
  localparam int COUNT_MASKED_LSB = 16;

  // ----------------------------------------
  // Mode register fields
  // ----------------------------------------
  localparam logic [2:0] MR_SEL_BURST = 3'h0;
  localparam logic [2:0] MR_SEL_TERM = 3'h1;
  localparam int TERM_EN_BIT = 2;
  localparam int TSTROBE_BIT = 11;
  localparam int CHOP_ADDR_BIT = 12;
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_CHOP4 = 2'h2;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic RTT_RESET = 1'b0;
  localparam logic TSTROBE_RESET = 1'b0;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_WORDS = 16;
  localparam logic [7:0] DQ_MASK_X8 = 8'hff;
  localparam logic [7:0] DQ_MASK_X4 = 8'h0f;

  typedef enum logic [4:0] {
    CMD_NOP = 5'b00001,
    CMD_LOAD = 5'b00010,
    CMD_READ = 5'b00100,
    CMD_WRITE = 5'b01000,
    CMD_OTHER = 5'b10000
  } dpi_cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } dpi_state_type;

endpackage

/* bench/dpi_ctrl_model.sv */
/*
  Memory controller model for the pin side: commands, termination and write beats.
  Assumes the caller issues one task at a time, just after a rising edge.
*/
module dpi_ctrl_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic [2:0] rcw_n_out,
  output logic [15:0] addr_out,
  output logic [2:0] bank_out,
  output logic term_en_out,
  output logic mask_out,
  output logic [7:0] dq_out,
  output logic dqs_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero: deselected, no operation
  initial begin
    cs_n_out = 1'b1;
    rcw_n_out = 3'b111;
    addr_out = 16'h0000;
    bank_out = 3'h0;
    term_en_out = 1'b0;
    mask_out = 1'b0;
    dq_out = 8'h00;
    dqs_out = 1'b0;
  end

  // One command cycle, then back to a no-operation code
  task automatic cmd(input logic csn, input logic [2:0] rcw, input logic [15:0] a, input logic [2:0] b);
    @(posedge clk_in);
    cs_n_out <= csn;
    rcw_n_out <= rcw;
    addr_out <= a;
    bank_out <= b;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    rcw_n_out <= 3'b111;
    addr_out <= ~a; // Stale address is not left on the pins
  endtask

  // Termination request, held from the next edge on
  task automatic set_term(input logic v);
    @(posedge clk_in);
    term_en_out <= v;
    @(posedge clk_in);
    @(posedge clk_in);
  endtask

  // Single data rate: each strobe toggle marks one beat; data sits mid-window
  task automatic wr(input int n, input logic [7:0] d [8], input logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      dqs_out <= ~dqs_out;
      dq_out <= d[i];
      mask_out <= m[i];
      @(posedge clk_in);
    end
    dq_out <= ~d[n-1]; // Released data shows the inverse, never the last beat
    mask_out <= ~m[n-1];
  endtask
endmodule

/* bench/dpi_top_tb_top.sv */
/*
  Self-checking bench for the pin interface: APB register access, mode loads,
  termination, masked writes filling the FIFO and strobed reads draining it.
  Assumes the controller model drives every pin-side input of the block except the device reset, which the bench drives.
*/
module dpi_top_tb_top import dpi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cs_n, term_en, wr_mask, dqs, dqs_o, dqs_c, dqs_oe, wr_rdy, t_dqs, t_mask, t_ts;
  logic [2:0] rcw, bank;
  logic [15:0] addr;
  logic [7:0] dq, dq_o, dq_oe, t_dq;
  logic [7:0] data [8];
  logic [7:0] oe_mask = 8'hff;
  logic [15:0] exp_q [$];
  logic prev_dqs = 1'b0;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  dpi_top i_dut (
    .CORE_CLK_IN(clk),
    .RST_IN(rst),
    .RESET_N_IN(rst_n),
    .PSEL_IN(psel),
    .PENABLE_IN(penable),
    .PWRITE_IN(pwrite),
    .PADDR_IN(paddr),
    .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata),
    .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr),
    .CHIP_SELECT_N_IN(cs_n),
    .ROW_CMD_STROBE_N_IN(rcw[2]),
    .COL_CMD_STROBE_N_IN(rcw[1]),
    .WRITE_CMD_STROBE_N_IN(rcw[0]),
    .ADDR_IN(addr),
    .BANK_IN(bank),
    .TERMINATION_ENABLE_IN(term_en),
    .WRITE_BYTE_MASK_IN(wr_mask),
    .DQ_IN(dq),
    .DQ_OUT(dq_o),
    .DQ_OE_OUT(dq_oe),
    .DATA_STROBE_IN(dqs),
    .DATA_STROBE_OUT(dqs_o),
    .DATA_STROBE_COMP_OUT(dqs_c),
    .DATA_STROBE_OE_OUT(dqs_oe),
    .WRITE_READY_OUT(wr_rdy),
    .TERM_DQ_OUT(t_dq),
    .TERM_DQS_OUT(t_dqs),
    .TERM_MASK_OUT(t_mask),
    .TERM_STROBE_OUT(t_ts)
  );

  dpi_ctrl_model i_ctrl (
    .clk_in(clk),
    .cs_n_out(cs_n),
    .rcw_n_out(rcw),
    .addr_out(addr),
    .bank_out(bank),
    .term_en_out(term_en),
    .mask_out(wr_mask),
    .dq_out(dq),
    .dqs_out(dqs)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // APB cycle; the answer is awaited, never assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Termination outputs as {strobe pair, mask ball, strobe, data lines}
  task automatic term(input logic v, input logic [10:0] exp);
    i_ctrl.set_term(v);
    #1;
    chk("termination", {21'h0, exp}, {21'h0, t_ts, t_mask, t_dqs, t_dq});
  endtask

  // Write command with random beats; beats flagged in st are noted for read back
  task automatic wr_burst(input logic csn, input logic [2:0] c, input logic [15:0] a, input int n,
                          input logic [7:0] m, input logic [7:0] st);
    for (int i = 0; i < 8; i++) data[i] = 8'($urandom);
    i_ctrl.cmd(csn, c, a, 3'h0);
    i_ctrl.wr(n, data, m);
    for (int i = 0; i < n; i++) if (st[i]) exp_q.push_back({oe_mask, data[i] & oe_mask});
  endtask

  // Read command; waits until the strobe driver lets go
  task automatic rd_burst(input logic [15:0] a);
    i_ctrl.cmd(1'b0, 3'b101, a, 3'h0);
    @(posedge clk);
    #1;
    chk("strobe drive", 32'h1, {31'h0, dqs_oe});
    while (dqs_oe === 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Read beat monitor: a strobe toggle while driving shows the oldest noted beat
  always @(posedge clk) begin
    if (dqs_oe === 1'b1 && dqs_o !== prev_dqs) begin
      if (exp_q.size() == 0)
        chk("unexpected beat", 32'h0, 32'h1);
      else
        chk("read beat", {16'h0, exp_q.pop_front()}, {16'h0, dq_oe, dq_o});
      chk("strobe comp", {31'h0, ~dqs_o}, {31'h0, dqs_c});
    end
    prev_dqs = dqs_o;
    cycles++;
    if (cycles > 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4da1));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", 32'h20, rd);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config reset", 32'h1, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, err});
    term(1'b1, 11'h000);
    i_ctrl.cmd(1'b0, 3'b000, 16'h0004, MR_SEL_TERM);
    term(1'b1, 11'h3ff);
    term(1'b0, 11'h000);
    // Masked beats, deselected and undefined commands; only 12 beats may land
    wr_burst(1'b0, 3'b100, 16'h0, 8, 8'h12, 8'hed);
    wr_burst(1'b1, 3'b100, 16'h0, 8, 8'h00, 8'h00);
    wr_burst(1'b0, 3'b110, 16'h0, 8, 8'h00, 8'h00);
    wr_burst(1'b0, 3'b100, 16'h0, 8, 8'hc0, 8'h3f);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("beat counts", 32'h0004000c, rd);
    rd_burst(16'h0);
    i_ctrl.cmd(1'b0, 3'b000, {14'h0, BURST_OTF}, MR_SEL_BURST);
    rd_burst(16'h0);
    // Strobe pair as termination: the mask is off, so masked beats are stored
    i_ctrl.cmd(1'b0, 3'b000, 16'h0804, MR_SEL_TERM);
    term(1'b1, 11'h5ff);
    wr_burst(1'b0, 3'b100, 16'h1000, 8, 8'hff, 8'hff);
    wr_burst(1'b0, 3'b100, 16'h1000, 8, 8'h00, 8'hff);
    #1;
    chk("write ready full", 32'h0, {31'h0, wr_rdy});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("fill count", 32'h10, rd >> STAT_FILL_LSB);
    rd_burst(16'h1000);
    rd_burst(16'h1000);
    // Narrow width: upper lines neither driven nor terminated
    apb(1'b1, ADDR_CONFIG, 32'h0);
    oe_mask = 8'h0f;
    i_ctrl.cmd(1'b0, 3'b000, {14'h0, BURST_CHOP4}, MR_SEL_BURST);
    i_ctrl.cmd(1'b0, 3'b000, 16'h0004, MR_SEL_TERM);
    term(1'b1, 11'h30f);
    wr_burst(1'b0, 3'b100, 16'h0, 4, 8'h00, 8'h0f);
    rd_burst(16'h0);
    chk("beats pending", 32'h0, exp_q.size());
    // Device reset in mid-read acts with no clock edge; the write is a chopped on-the-fly burst
    i_ctrl.cmd(1'b0, 3'b000, {14'h0, BURST_OTF}, MR_SEL_BURST);
    wr_burst(1'b0, 3'b100, 16'h0, 4, 8'h00, 8'h00);
    i_ctrl.cmd(1'b0, 3'b101, 16'h0, 3'h0);
    @(posedge clk);
    #7 rst_n = 1'b0;
    #1;
    chk("reset drivers", 32'h0, {12'h0, dq_oe, dqs_oe, t_dq, t_dqs, t_mask, t_ts});
    repeat (2) @(posedge clk);
    #7 rst_n = 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status after reset", 32'h20, {24'h0, rd[7:0]});
    stop_test();
  end
endmodule
